// ==== tb/dual_pot_properties.sv ====
// Port assertions for the dual pot serial command logic.
// Assumes it is bound to the design top module.
`timescale 1ns/100ps
`default_nettype none
module dual_pot_properties
#(
  parameter int NV_CYCLES = 200
)
(
  input wire logic         clock,
  input wire logic         sys_rst,
  input wire logic         clk_en,
  input wire logic         serial_clock,
  input wire logic         sda_in,
  input wire logic         sda_out,
  input wire logic         sda_oe,
  input wire logic [3:0]   chip_select_bits,
  input wire logic         write_protect_n,
  input wire logic [255:0] tap_select_0,
  input wire logic [255:0] tap_select_1,
  input wire logic         nv_busy
);
  typedef struct packed {logic [31:0] busy_cnt;} chk_state_type;
  chk_state_type s_q;
  chk_state_type s_d;
  always_comb
  begin
    s_d          = s_q;
    s_d.busy_cnt = nv_busy ? s_q.busy_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  tap_one_hot_a: assert property (!$past(sys_rst) |-> $onehot(tap_select_0) && $onehot(tap_select_1))
    else $error("tap select not one-hot");
  power_up_recall_a: assert property ($fell(sys_rst) |-> ##[1:4] tap_select_0[128] && tap_select_1[128])
    else $error("wipers not recalled after reset");
  busy_bound_a: assert property (nv_busy |-> s_q.busy_cnt <= NV_CYCLES)
    else $error("program cycle too long");
  busy_min_a: assert property ($rose(nv_busy) |-> nv_busy[*8])
    else $error("program cycle dropped early");
  busy_silent_a: assert property (nv_busy |-> !sda_oe)
    else $error("data line driven while programming");
  busy_after_stop_a: assert property ($rose(nv_busy) |-> serial_clock && sda_in)
    else $error("programming started outside a stop");
  ack_stands_a: assert property (serial_clock && $past(serial_clock) |-> $stable(sda_oe))
    else $error("data output moved while clock high");
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data output drives high");
  cover property ($rose(nv_busy));
  cover property ($rose(sda_oe));
  cover property (tap_select_0[255]);
endmodule : dual_pot_properties

bind dual_pot_serial_command_logic dual_pot_properties #(.NV_CYCLES(NV_CYCLES)) i_dual_pot_properties
(
  .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .serial_clock(serial_clock),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bits(chip_select_bits),
  .write_protect_n(write_protect_n), .tap_select_0(tap_select_0), .tap_select_1(tap_select_1),
  .nv_busy(nv_busy)
);
`default_nettype wire

// ==== tb/dual_pot_serial_command_logic_bench.sv ====
// Self-checking bench for the dual pot serial command logic.
// Assumes the bus master model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`include "dual_pot_params.svh"
module dual_pot_serial_command_logic_bench;
  localparam int         NV  = 200;
  localparam logic [3:0] CS  = 4'hA;
  localparam logic [7:0] ADR = {`DEV_TYPE_ID, CS};
  logic         clock;
  logic         sys_rst;
  logic         write_protect_n;
  logic         serial_clock;
  logic         sda_low;
  logic         sda_in;
  logic         sda_out;
  logic         sda_oe;
  logic         nv_busy;
  logic [255:0] tap_select_0;
  logic [255:0] tap_select_1;
  logic [7:0]   rd;
  int           failures;
  int           checked;
  assign sda_in = !(sda_low || sda_oe);
  dual_pot_serial_command_logic #(.NV_CYCLES(NV)) i_dual_pot_serial_command_logic
  (
    .clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .serial_clock(serial_clock),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bits(CS),
    .write_protect_n(write_protect_n), .tap_select_0(tap_select_0),
    .tap_select_1(tap_select_1), .nv_busy(nv_busy)
  );
  pot_bus_master i_pot_bus_master (.serial_clock(serial_clock), .sda_low(sda_low), .sda_oe(sda_oe));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = !clock;
  end
  ////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic check_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_byte
  task automatic check_tap(input string name, input logic [7:0] pos, input logic [255:0] got);
    logic [255:0] exp;
    exp = 256'h1 << pos;
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected tap %0d seen %h", name, pos, got);
    end
  endtask : check_tap
  function automatic logic [7:0] ins(input logic [3:0] op, input logic [1:0] sel, input logic pot);
    return {op, sel, 1'b0, pot};
  endfunction : ins
  // Kind: 0 address only, 1 copy, 2 write, 3 read, 4 step pulses
  task automatic cmd(input logic [7:0] adr, input logic [7:0] ib, input int kind, input logic [7:0] wd,
                     input logic [2:0] acks);
    logic a;
    i_pot_bus_master.frame_start();
    i_pot_bus_master.send_byte(adr, a);
    check_bit("address ack", acks[2], a);
    if (kind > 0)
    begin
      i_pot_bus_master.send_byte(ib, a);
      check_bit("instruction ack", acks[1], a);
    end
    if (kind == 2)
    begin
      i_pot_bus_master.send_byte(wd, a);
      check_bit("data ack", acks[0], a);
    end
    if (kind == 3)
      i_pot_bus_master.get_byte(rd);
    if (kind == 4)
      for (int i = 0; i < wd[3:0]; i++)
        i_pot_bus_master.bit_cycle(wd[7], a);
    i_pot_bus_master.frame_stop();
  endtask : cmd
  task automatic rdc(input logic [3:0] op, input logic [1:0] sel, input logic pot, input logic [7:0] exp);
    cmd(ADR, ins(op, sel, pot), 3, 8'h00, 3'h6);
    check_byte("read data", exp, rd);
  endtask : rdc
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (8) @(posedge clock);
    while (nv_busy !== 1'b0 && n < NV + 50)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= NV + 50)
    begin
      failures++;
      $display("[FAIL] nv_busy expected 0 seen 1");
      print_verdict();
    end
  endtask : wait_idle
  task automatic set_wp(input logic v);
    @(posedge clock);
    #1 write_protect_n = v;
  endtask : set_wp
  ////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst         = 1'b1;
    write_protect_n = 1'b1;
    failures        = 0;
    checked         = 0;
    repeat (3) @(posedge clock);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge clock);
    rdc(`OP_READ_WIPER, 2'h0, 1'b0, `SETTING_INIT);
    rdc(`OP_READ_WIPER, 2'h0, 1'b1, `SETTING_INIT);
    check_tap("tap 0", `SETTING_INIT, tap_select_0);
    cmd(ADR, ins(`OP_WRITE_WIPER, 2'h0, 1'b0), 2, 8'h3C, 3'h7);
    rdc(`OP_READ_WIPER, 2'h0, 1'b0, 8'h3C);
    check_tap("tap 0", 8'h3C, tap_select_0);
    cmd({`DEV_TYPE_ID, ~CS}, ins(`OP_WRITE_WIPER, 2'h0, 1'b0), 2, 8'h11, 3'h0);
    cmd({~`DEV_TYPE_ID, CS}, ins(`OP_WRITE_WIPER, 2'h0, 1'b0), 2, 8'h22, 3'h0);
    rdc(`OP_READ_WIPER, 2'h0, 1'b0, 8'h3C);
    cmd(ADR, ins(`OP_WRITE_SETTING, 2'h1, 1'b1), 2, 8'hA5, 3'h7);
    cmd(ADR, 8'h00, 0, 8'h00, 3'h0);
    wait_idle();
    rdc(`OP_READ_SETTING, 2'h1, 1'b1, 8'hA5);
    rdc(`OP_READ_SETTING, 2'h0, 1'b1, `SETTING_INIT);
    cmd(ADR, ins(`OP_SETTING_TO_WIPER, 2'h1, 1'b1), 1, 8'h00, 3'h6);
    wait_idle();
    rdc(`OP_READ_WIPER, 2'h0, 1'b1, 8'hA5);
    check_tap("tap 1", 8'hA5, tap_select_1);
    cmd(ADR, ins(`OP_WIPER_TO_SETTING, 2'h2, 1'b0), 1, 8'h00, 3'h6);
    wait_idle();
    rdc(`OP_READ_SETTING, 2'h2, 1'b0, 8'h3C);
    cmd(ADR, ins(`OP_GANG_TO_SETTING, 2'h3, 1'b0), 1, 8'h00, 3'h6);
    wait_idle();
    rdc(`OP_READ_SETTING, 2'h3, 1'b0, 8'h3C);
    rdc(`OP_READ_SETTING, 2'h3, 1'b1, 8'hA5);
    cmd(ADR, ins(`OP_GANG_TO_WIPER, 2'h0, 1'b0), 1, 8'h00, 3'h6);
    wait_idle();
    rdc(`OP_READ_WIPER, 2'h0, 1'b0, `SETTING_INIT);
    cmd(ADR, ins(`OP_WRITE_WIPER, 2'h0, 1'b0), 2, 8'hFD, 3'h7);
    cmd(ADR, ins(`OP_STEP, 2'h0, 1'b0), 4, 8'h83, 3'h6);
    rdc(`OP_READ_WIPER, 2'h0, 1'b0, `WIPER_MAX);
    rdc(`OP_READ_WIPER, 2'h0, 1'b1, `SETTING_INIT);
    cmd(ADR, ins(`OP_STEP, 2'h0, 1'b0), 4, 8'h02, 3'h6);
    rdc(`OP_READ_WIPER, 2'h0, 1'b0, 8'hFD);
    cmd(ADR, ins(`OP_WRITE_WIPER, 2'h0, 1'b1), 2, 8'h01, 3'h7);
    cmd(ADR, ins(`OP_STEP, 2'h0, 1'b1), 4, 8'h03, 3'h6);
    rdc(`OP_READ_WIPER, 2'h0, 1'b1, `WIPER_MIN);
    set_wp(1'b0);
    cmd(ADR, ins(`OP_WRITE_SETTING, 2'h0, 1'b0), 2, 8'h11, 3'h6);
    repeat (20) @(posedge clock);
    check_bit("nv_busy", 1'b0, nv_busy);
    rdc(`OP_READ_SETTING, 2'h0, 1'b0, `SETTING_INIT);
    set_wp(1'b1);
    fork
      cmd(ADR, ins(`OP_WRITE_SETTING, 2'h0, 1'b0), 2, 8'h22, 3'h6);
      begin
        repeat (80) @(posedge clock);
        #1 write_protect_n = 1'b0;
      end
    join
    rdc(`OP_READ_SETTING, 2'h0, 1'b0, `SETTING_INIT);
    set_wp(1'b1);
    cmd(ADR, ins(`OP_WRITE_SETTING, 2'h0, 1'b1), 2, 8'h5A, 3'h7);
    repeat (20) @(posedge clock);
    #1 write_protect_n = 1'b0;
    wait_idle();
    rdc(`OP_READ_SETTING, 2'h0, 1'b1, 8'h5A);
    print_verdict();
  end
endmodule : dual_pot_serial_command_logic_bench
`default_nettype wire

// ==== tb/pot_bus_master.sv ====
// Two-wire bus master model driving serial clock and data.
// Assumes a pull-up on the data line; clock idles high between frames.
`timescale 1ns/100ps
`default_nettype none
module pot_bus_master
(
  output logic      serial_clock,
  output logic      sda_low,
  input  wire logic sda_oe
);
  logic sda_line;
  assign sda_line = !(sda_low || sda_oe);
  initial
  begin
    serial_clock = 1'b1;
    sda_low      = 1'b0;
  end
  task automatic frame_start;
    sda_low = 1'b0;
    #5 serial_clock = 1'b1;
    #20 sda_low = 1'b1;
    #20 serial_clock = 1'b0;
    #5;
  endtask : frame_start
  task automatic frame_stop;
    sda_low = 1'b1;
    #5 serial_clock = 1'b1;
    #20 sda_low = 1'b0;
    #20;
  endtask : frame_stop
  task automatic bit_cycle(input logic b, output logic seen);
    sda_low = !b;
    #8 serial_clock = 1'b1;
    #7 seen = sda_line;
    #8 serial_clock = 1'b0;
    #7;
  endtask : bit_cycle
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(b[i], s);
    bit_cycle(1'b1, s);
    ack = !s;
  endtask : send_byte
  task automatic get_byte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b1, b[i]);
    bit_cycle(1'b1, s);
  endtask : get_byte
endmodule : pot_bus_master
`default_nettype wire

// ==== verilog/dual_pot_params.svh ====
// Constants for the dual potentiometer serial command logic.
// Assumes inclusion by bare name from the design files.
`ifndef DUAL_POT_PARAMS_SVH
`define DUAL_POT_PARAMS_SVH
`define DEV_TYPE_ID        4'h5
`define OP_READ_WIPER      4'h9
`define OP_WRITE_WIPER     4'hA
`define OP_READ_SETTING    4'hB
`define OP_WRITE_SETTING   4'hC
`define OP_SETTING_TO_WIPER 4'hD
`define OP_WIPER_TO_SETTING 4'hE
`define OP_GANG_TO_WIPER   4'h1
`define OP_GANG_TO_SETTING 4'h8
`define OP_STEP            4'h2
`define SEL_ZERO           2'h0
`define WIPER_MAX          8'hFF
`define WIPER_MIN          8'h00
`define SETTING_INIT       8'h80
`define NV_WRITE_MS        10
`define CLOCK_MHZ          200
`define NV_WRITE_CYCLES    (`NV_WRITE_MS * 1000 * `CLOCK_MHZ)
`define NV_CNT_W           21
`define BIT_LAST           4'h7
`define BIT_ACK            4'h8
`endif

// ==== verilog/dual_pot_pkg.sv ====
// Types shared by the dual potentiometer command logic.
// Assumes no surroundings beyond the params header.
package dual_pot_pkg;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ADDR  = 8'h02,
    ST_INSTR = 8'h04,
    ST_WDATA = 8'h08,
    ST_RDATA = 8'h10,
    ST_STEP  = 8'h20,
    ST_WAITP = 8'h40,
    ST_IGN   = 8'h80
  } link_state_type;
endpackage : dual_pot_pkg

// ==== verilog/dual_pot_serial_command_logic.sv ====
// Slave command logic of a dual digital potentiometer on a two-wire bus.
// Assumes the serial clock arrives as a link clock port; open-drain SDA resolved outside.
`timescale 1ns/100ps
`default_nettype none
`include "dual_pot_params.svh"

module dual_pot_serial_command_logic
#(
  parameter int NV_CYCLES = `NV_WRITE_CYCLES
)
(
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic         serial_clock,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  input  wire logic [3:0]   chip_select_bits,
  input  wire logic         write_protect_n,
  output logic [255:0]      tap_select_0,
  output logic [255:0]      tap_select_1,
  output logic              nv_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain state

  typedef struct packed {
    dual_pot_pkg::link_state_type st;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [3:0]  opcode;
    logic [1:0]  rsel;
    logic [1:0]  psel;
    logic        ack;
    logic        drive;
    logic        req_tgl;
    logic [2:0]  req_kind;
    logic [7:0]  req_data;
    logic [1:0]  req_rsel;
    logic [1:0]  req_psel;
    logic        pend;
  } link_type;

  localparam logic [2:0] K_WWIPER = 3'h1;
  localparam logic [2:0] K_WSET   = 3'h2;
  localparam logic [2:0] K_S2W    = 3'h3;
  localparam logic [2:0] K_W2S    = 3'h4;
  localparam logic [2:0] K_G2W    = 3'h5;
  localparam logic [2:0] K_G2S    = 3'h6;
  localparam logic [2:0] K_UP     = 3'h7;
  localparam logic [2:0] K_DOWN   = 3'h0;

  link_type l_q;
  link_type l_d;

  // Start and stop are seen on sda edges while the serial clock is high
  logic start_tgl_q;
  logic stop_tgl_q;

  // Values from the core clock domain; busy and protect double-flopped, wiper copies single-flopped into the link domain
  logic [1:0] busy_sync_q;
  logic [1:0] wp_link_sync_q;
  logic [7:0] rd_wiper0_q;
  logic [7:0] rd_wiper1_q;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain state

  typedef struct packed {
    logic [7:0]  wiper0;
    logic [7:0]  wiper1;
    logic [3:0][7:0] set0;
    logic [3:0][7:0] set1;
    logic [2:0]  req_sync;
    logic [2:0]  stop_sync;
    logic [1:0]  wp_sync;
    logic        busy;
    logic        nv_armed;
    logic        boot;
    logic [`NV_CNT_W-1:0] nv_cnt;
    logic        nv_pot;
    logic        nv_gang;
    logic [1:0]  nv_rsel;
    logic [7:0]  nv_val0;
    logic [7:0]  nv_val1;
    logic        nv_to_wiper;
  } core_type;

  core_type c_q;
  core_type c_d;

  function automatic logic [7:0] sel_setting(input core_type c, input logic pot, input logic [1:0] r);
    sel_setting = pot ? c.set1[r] : c.set0[r];
  endfunction : sel_setting

  function automatic logic [255:0] tap_decode(input logic [7:0] w);
    tap_decode = 256'h0;
    tap_decode[w] = 1'b1;
  endfunction : tap_decode

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop detection on the data line

  always_ff @(negedge sda_in or posedge sys_rst)
  begin
    if (sys_rst)
      start_tgl_q <= 1'b0;
    else if (serial_clock)
      start_tgl_q <= ~start_tgl_q;
  end

  always_ff @(posedge sda_in or posedge sys_rst)
  begin
    if (sys_rst)
      stop_tgl_q <= 1'b0;
    else if (serial_clock)
      stop_tgl_q <= ~stop_tgl_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the link domain

  always_ff @(negedge serial_clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_sync_q    <= 2'h0;
      wp_link_sync_q <= 2'h0;
      rd_wiper0_q    <= 8'h00;
      rd_wiper1_q    <= 8'h00;
    end
    else
    begin
      busy_sync_q    <= {busy_sync_q[0], c_q.busy};
      wp_link_sync_q <= {wp_link_sync_q[0], write_protect_n};
      rd_wiper0_q    <= c_q.wiper0;
      rd_wiper1_q    <= c_q.wiper1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine, advanced on falling serial clock edges

  logic start_ev;
  logic start_ack_q;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;

  // Start is acted on at the first falling clock after it; stop is handled in the core domain
  assign start_ev = start_tgl_q ^ start_ack_q;
  assign byte_in  = l_q.shreg;

  always_comb
  begin
    unique case (l_q.opcode)
      `OP_READ_WIPER:   rd_byte = l_q.psel[0] ? rd_wiper1_q : rd_wiper0_q;
      default:          rd_byte = sel_setting(c_q, l_q.psel[0], l_q.rsel);
    endcase
  end

  always_comb
  begin
    l_d = l_q;
    l_d.ack = 1'b0;
    l_d.drive = 1'b0;
    l_d.shreg = {l_q.shreg[6:0], sda_in};
    l_d.bit_cnt = l_q.bit_cnt + 4'h1;
    if (start_ev)
    begin
      l_d.st = dual_pot_pkg::ST_ADDR;
      l_d.bit_cnt = 4'h0;
      l_d.shreg = 8'h00;
      l_d.pend = 1'b0;
    end
    else
    begin
      unique case (l_q.st)
        dual_pot_pkg::ST_ADDR:
        begin
          if (l_q.bit_cnt == `BIT_LAST)
          begin
            if (l_d.shreg[7:4] == `DEV_TYPE_ID && l_d.shreg[3:0] == chip_select_bits && ~busy_sync_q[1])
              l_d.ack = 1'b1;
            else
              l_d.st = dual_pot_pkg::ST_IGN;
          end
          if (l_q.bit_cnt == `BIT_ACK)
          begin
            l_d.st = dual_pot_pkg::ST_INSTR;
            l_d.bit_cnt = 4'h0;
          end
        end
        dual_pot_pkg::ST_INSTR:
        begin
          if (l_q.bit_cnt == `BIT_LAST)
          begin
            l_d.ack = 1'b1;
            l_d.opcode = l_d.shreg[7:4];
            l_d.rsel = l_d.shreg[3:2];
            l_d.psel = l_d.shreg[1:0];
          end
          if (l_q.bit_cnt == `BIT_ACK)
          begin
            l_d.bit_cnt = 4'h0;
            l_d.req_rsel = l_q.rsel;
            l_d.req_psel = l_q.psel;
            unique case (l_q.opcode)
              `OP_READ_WIPER, `OP_READ_SETTING:
              begin
                l_d.st = dual_pot_pkg::ST_RDATA;
                l_d.shreg = rd_byte;
                l_d.drive = ~rd_byte[7];
              end
              `OP_WRITE_WIPER, `OP_WRITE_SETTING: l_d.st = dual_pot_pkg::ST_WDATA;
              `OP_SETTING_TO_WIPER:
              begin
                l_d.st = dual_pot_pkg::ST_WAITP;
                l_d.req_kind = K_S2W;
                l_d.pend = 1'b1;
              end
              `OP_WIPER_TO_SETTING:
              begin
                l_d.st = dual_pot_pkg::ST_WAITP;
                l_d.req_kind = K_W2S;
                l_d.pend = 1'b1;
              end
              `OP_GANG_TO_WIPER:
              begin
                l_d.st = dual_pot_pkg::ST_WAITP;
                l_d.req_kind = K_G2W;
                l_d.pend = 1'b1;
              end
              `OP_GANG_TO_SETTING:
              begin
                l_d.st = dual_pot_pkg::ST_WAITP;
                l_d.req_kind = K_G2S;
                l_d.pend = 1'b1;
              end
              `OP_STEP: l_d.st = dual_pot_pkg::ST_STEP;
              default:  l_d.st = dual_pot_pkg::ST_IGN;
            endcase
          end
        end
        dual_pot_pkg::ST_WDATA:
        begin
          if (l_q.bit_cnt == `BIT_LAST)
          begin
            l_d.req_data = l_d.shreg;
            if (l_q.opcode == `OP_WRITE_WIPER)
            begin
              l_d.ack = 1'b1;
              l_d.req_kind = K_WWIPER;
              l_d.req_tgl = ~l_q.req_tgl;
            end
            else if (wp_link_sync_q[1])
            begin
              l_d.ack = 1'b1;
              l_d.req_kind = K_WSET;
              l_d.pend = 1'b1;
            end
          end
          if (l_q.bit_cnt == `BIT_ACK)
            l_d.st = dual_pot_pkg::ST_WAITP;
        end
        dual_pot_pkg::ST_RDATA:
        begin
          l_d.shreg = {l_q.shreg[6:0], 1'b1};
          l_d.drive = (l_q.bit_cnt < `BIT_LAST) && ~l_q.shreg[6];
          if (l_q.bit_cnt == `BIT_ACK)
            l_d.st = dual_pot_pkg::ST_WAITP;
        end
        dual_pot_pkg::ST_STEP:
        begin
          l_d.req_kind = sda_in ? K_UP : K_DOWN;
          l_d.req_tgl = ~l_q.req_tgl;
        end
        default: l_d.bit_cnt = l_q.bit_cnt;
      endcase
    end
  end

  always_ff @(negedge serial_clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      l_q <= '{st: dual_pot_pkg::ST_IDLE, default: '0};
      start_ack_q <= 1'b0;
    end
    else
    begin
      l_q <= l_d;
      start_ack_q <= start_tgl_q;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = l_q.ack | l_q.drive;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: register file, copies and nonvolatile timing

  logic core_req;
  logic stop_req;
  // A stop ending a pending stored write or copy launches it; protect low at the stop or in the first busy cycle aborts stored writes
  assign stop_req = (c_q.stop_sync[2] ^ c_q.stop_sync[1]) && l_q.pend
                    && (c_q.wp_sync[1] || l_q.req_kind == K_S2W || l_q.req_kind == K_G2W);
  assign core_req = (c_q.req_sync[2] ^ c_q.req_sync[1]) || stop_req;

  always_comb
  begin
    c_d = c_q;
    c_d.req_sync = {c_q.req_sync[1:0], l_q.req_tgl};
    c_d.stop_sync = {c_q.stop_sync[1:0], stop_tgl_q};
    c_d.wp_sync = {c_q.wp_sync[0], write_protect_n};
    if (c_q.boot)
    begin
      c_d.boot = 1'b0;
      c_d.wiper0 = c_q.set0[`SEL_ZERO];
      c_d.wiper1 = c_q.set1[`SEL_ZERO];
    end
    else if (c_q.busy)
    begin
      if (c_q.nv_armed && ~c_q.wp_sync[1] && ~c_q.nv_to_wiper)
      begin
        c_d.busy = 1'b0;
        c_d.nv_armed = 1'b0;
      end
      else if (c_q.nv_cnt == `NV_CNT_W'(NV_CYCLES - 1))
      begin
        c_d.busy = 1'b0;
        if (c_q.nv_to_wiper)
        begin
          if (c_q.nv_gang || ~c_q.nv_pot)
            c_d.wiper0 = c_q.nv_val0;
          if (c_q.nv_gang || c_q.nv_pot)
            c_d.wiper1 = c_q.nv_val1;
        end
        else
        begin
          if (c_q.nv_gang || ~c_q.nv_pot)
            c_d.set0[c_q.nv_rsel] = c_q.nv_val0;
          if (c_q.nv_gang || c_q.nv_pot)
            c_d.set1[c_q.nv_rsel] = c_q.nv_val1;
        end
      end
      else
      begin
        c_d.nv_cnt = c_q.nv_cnt + `NV_CNT_W'(1);
        c_d.nv_armed = 1'b0;
      end
    end
    else if (core_req)
    begin
      c_d.nv_rsel = l_q.req_rsel;
      c_d.nv_pot = l_q.req_psel[0];
      c_d.nv_gang = (l_q.req_kind == K_G2W) || (l_q.req_kind == K_G2S);
      c_d.nv_cnt = '0;
      unique case (l_q.req_kind)
        K_WWIPER:
        begin
          if (l_q.req_psel[0])
            c_d.wiper1 = l_q.req_data;
          else
            c_d.wiper0 = l_q.req_data;
        end
        K_UP, K_DOWN:
        begin
          if (l_q.req_psel[0])
            c_d.wiper1 = (l_q.req_kind == K_UP) ? ((c_q.wiper1 == `WIPER_MAX) ? `WIPER_MAX : c_q.wiper1 + 8'h01)
                                                : ((c_q.wiper1 == `WIPER_MIN) ? `WIPER_MIN : c_q.wiper1 - 8'h01);
          else
            c_d.wiper0 = (l_q.req_kind == K_UP) ? ((c_q.wiper0 == `WIPER_MAX) ? `WIPER_MAX : c_q.wiper0 + 8'h01)
                                                : ((c_q.wiper0 == `WIPER_MIN) ? `WIPER_MIN : c_q.wiper0 - 8'h01);
        end
        K_WSET:
        begin
          c_d.busy = 1'b1;
          c_d.nv_armed = 1'b1;
          c_d.nv_to_wiper = 1'b0;
          c_d.nv_val0 = l_q.req_data;
          c_d.nv_val1 = l_q.req_data;
        end
        K_S2W, K_G2W:
        begin
          c_d.busy = 1'b1;
          c_d.nv_to_wiper = 1'b1;
          c_d.nv_val0 = c_q.set0[l_q.req_rsel];
          c_d.nv_val1 = c_q.set1[l_q.req_rsel];
        end
        default:
        begin
          c_d.busy = 1'b1;
          c_d.nv_armed = 1'b1;
          c_d.nv_to_wiper = 1'b0;
          c_d.nv_val0 = c_q.wiper0;
          c_d.nv_val1 = c_q.wiper1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      c_q <= '{set0: {4{`SETTING_INIT}}, set1: {4{`SETTING_INIT}}, boot: 1'b1, default: '0};
    end
    else if (clk_en)
      c_q <= c_d;
  end

  assign tap_select_0 = tap_decode(c_q.wiper0);
  assign tap_select_1 = tap_decode(c_q.wiper1);
  assign nv_busy = c_q.busy;

endmodule : dual_pot_serial_command_logic
`default_nettype wire
